// *** ccu_pin_model.sv ***
// Far-side model of the channel pins and the external count sources
module ccu_pin_model
  import ccu_pkg::*;
(
  input  wire logic [NCH-1:0] cc_out,
  input  wire logic [NCH-1:0] cc_oe,
  input  wire logic           clk,
  output logic [NCH-1:0]      cc_in,
  output logic [1:0]          ext_cnt,
  output logic                gpt_ovf
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Pin levels
  // ************************************************************
  logic [NCH-1:0] lvl   = '0;
  logic [1:0]     ext_q = 2'h0;
  logic           gpt_q = 1'b0;

  // Driven channels show their own output, others the far-side level
  assign cc_in   = (cc_oe & cc_out) | (~cc_oe & lvl);
  assign ext_cnt = ext_q;
  assign gpt_ovf = gpt_q;

  // ************************************************************
  // Event tasks
  // ************************************************************
  // One pin level change, just after an edge
  task automatic set_pin(input int ch, input logic val);
    @(posedge clk) lvl[ch] <= val;
  endtask

  // Same count signal on the selected first-timer inputs
  task automatic ext_pulses(input logic [1:0] msk, input int n);
    repeat (n) begin
      @(posedge clk) ext_q <= msk;
      @(posedge clk);
      @(posedge clk) ext_q <= 2'h0;
      @(posedge clk);
    end
  endtask

  // One-cycle overflow pulse of the general timer, then settle time
  task automatic gpt_pulse();
    @(posedge clk) gpt_q <= 1'b1;
    @(posedge clk) gpt_q <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
endmodule

// *** ccu_pkg.sv ***
// Constants and types for the dual capture/compare array
package ccu_pkg;

  // ************************************************************
  // Sizes and timing
  // ************************************************************
  localparam int NCH      = 32;                        // Channels of both units
  localparam int NUNIT_CH = 16;                        // Channels per unit
  localparam int NHALF    = 8;                         // Double-register partner distance
  localparam int NTMR     = 4;                         // Two timers per unit
  localparam int TW       = 16;                        // Timer and channel width
  localparam int REF_MHZ  = 40;                        // Reference CPU clock
  localparam int RES_NS   = 200;                       // Finest resolution at reference
  localparam int MIN_DIV  = RES_NS * REF_MHZ / 1000;   // Smallest prescale factor
  localparam int PRESC_W  = 10;                        // Prescaler width, up to 1024
  localparam logic [NCH-1:0] NO_OUT_MASK = 32'h0F00_0000; // Capture-only channels

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [31:0] CCV_BASE   = 32'h0000_0000; // Channel value, 32 words
  localparam logic [31:0] CFG_BASE   = 32'h0000_0080; // Channel mode, 32 words
  localparam logic [31:0] IC_BASE    = 32'h0000_0100; // Interrupt control, 32 words
  localparam logic [31:0] TV_BASE    = 32'h0000_0180; // Timer value, 4 words
  localparam logic [31:0] TR_BASE    = 32'h0000_0190; // Timer reload, 4 words
  localparam logic [31:0] TC_BASE    = 32'h0000_01A0; // Timer control, 4 words
  localparam logic [2:0]  HSIZE_WORD = 3'h2;          // Only whole-word writes
  localparam logic [7:0]  IC_RESET   = 8'h00;         // Interrupt control after reset

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    MD_OFF = 4'h0, CAP_RISE = 4'h1, CAP_FALL = 4'h2, CAP_BOTH = 4'h3,
    CMP0 = 4'h4, CMP1 = 4'h5, CMP2 = 4'h6, CMP3 = 4'h7, CMP_DBL = 4'h8
  } ccu_mode_e;

  typedef enum logic [1:0] {
    SRC_PRESC = 2'h0, SRC_GPT = 2'h1, SRC_EXT = 2'h2
  } ccu_src_e;

  typedef enum logic [2:0] {
    K_NONE = 3'h0, K_CCV = 3'h1, K_CFG = 3'h2, K_IC = 3'h3,
    K_TV = 3'h4, K_TR = 3'h5, K_TC = 3'h6
  } ccu_kind_e;

  typedef struct packed {
    logic      run;   // Bit 5
    ccu_src_e  src;   // Bits 4:3
    logic [2:0] isel; // Bits 2:0, input_select
  } ccu_tctl_s;

  typedef struct packed {
    logic      tsel;  // Bit 4, 0 timer a, 1 timer b
    ccu_mode_e mode;  // Bits 3:0
  } ccu_chcfg_s;

  typedef struct packed {
    logic       request_flag;   // Bit 7
    logic       source_enable;  // Bit 6
    logic [3:0] priority_level; // Bits 5:2
    logic [1:0] group_level;    // Bits 1:0
  } ccu_ic_s;

  typedef struct packed {
    logic [NCH-1:0][TW-1:0]  ccv;
    ccu_chcfg_s [NCH-1:0]    cfg;
    ccu_ic_s [NCH-1:0]       ic;
    logic [NTMR-1:0][TW-1:0] tv;
    logic [NTMR-1:0][TW-1:0] tr;
    ccu_tctl_s [NTMR-1:0]    tc;
    logic [PRESC_W-1:0]      presc;
    logic [NCH-1:0]          pin_q;
    logic [NCH-1:0]          pout;
    logic [NCH-1:0]          done;
    logic [NTMR-1:0]         upd;
    logic [1:0]              ext_q;
    logic                    dph;
    logic                    dwr;
    logic                    rdw;
    logic [31:0]             dadr;
    logic [31:0]             rdata;
  } ccu_state_s;

  localparam ccu_state_s ST_RESET = '0;

endpackage

// *** ccu_top.sv ***
// Dual capture/compare array with four reloadable timers and an AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
module ccu_top
  import ccu_pkg::*;
#(
  parameter int UNITS = 2
) (
  input  logic                 CLK_SYS,
  input  logic                 ARST_N,
  input  logic                 HSEL,
  input  logic [31:0]          HADDR,
  input  logic [1:0]           HTRANS,
  input  logic                 HWRITE,
  input  logic [2:0]           HSIZE,
  input  logic [31:0]          HWDATA,
  input  logic                 HREADY,
  output logic                 HREADYOUT,
  output logic [31:0]          HRDATA,
  output logic                 HRESP,
  input  logic [NCH-1:0]       CC_IN,
  output logic [NCH-1:0]       CC_OUT,
  output logic [NCH-1:0]       CC_OE,
  input  logic [1:0]           EXT_CNT,
  input  logic                 GPT_OVF,
  output logic [NCH-1:0]       IRQ_REQ,
  output ccu_ic_s [NCH-1:0]    SRC_CTRL
);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (UNITS != 2) begin : g_bad_units
    $error("ccu_top serves exactly two units");
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  // Register kind for an address
  function automatic ccu_kind_e dec(input logic [31:0] a);
    dec = K_NONE;
    if (a[31:9] == 23'h0 && a[1:0] == 2'h0) begin
      if (a[8:7] == CCV_BASE[8:7]) dec = K_CCV;
      else if (a[8:7] == CFG_BASE[8:7]) dec = K_CFG;
      else if (a[8:7] == IC_BASE[8:7]) dec = K_IC;
      else if (a[6:4] == TV_BASE[6:4]) dec = K_TV;
      else if (a[6:4] == TR_BASE[6:4]) dec = K_TR;
      else if (a[6:4] == TC_BASE[6:4]) dec = K_TC;
    end
  endfunction

  // All-ones mask of the prescale counter for a selected division
  function automatic logic [PRESC_W-1:0] presc_mask(input logic [2:0] isel);
    presc_mask = PRESC_W'((MIN_DIV << isel) - 1);
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  ccu_state_s s;
  ccu_state_s next_s;

  wire  [NTMR-1:0]         tick;
  wire  [NTMR-1:0]         ovf;
  wire  [1:0]              ext_rise;
  wire  [NCH-1:0][TW-1:0]  cur_t;
  wire  [NCH-1:0]          ovf_ch;
  wire  [NCH-1:0]          cap_ev;
  wire  [NCH-1:0]          match_ev;
  wire  [NCH-1:0]          once;
  wire  [NCH-1:0]          hit;
  wire  [NCH-1:0]          ptog;
  wire  [NCH-1:0]          tog;
  wire  [NCH-1:0]          drv;
  logic                    accept;
  logic                    wr_now;
  logic [4:0]              ci;
  logic [1:0]              ti;

  // Bus decode terms
  assign accept   = HSEL && HTRANS[1] && HREADY;
  assign wr_now   = s.dph && s.dwr;
  assign ci       = s.dadr[6:2];
  assign ti       = s.dadr[3:2];
  assign ext_rise = EXT_CNT & ~s.ext_q;

  // ************************************************************
  // Timer ticks
  // ************************************************************
  for (genvar gt = 0; gt < NTMR; gt++) begin : g_tmr
    logic src_tick;
    // Input selection per timer
    always_comb begin
      unique case (s.tc[gt].src)
        SRC_PRESC: src_tick = (s.presc & presc_mask(s.tc[gt].isel))
                              == presc_mask(s.tc[gt].isel);
        SRC_GPT:   src_tick = GPT_OVF;
        SRC_EXT:   src_tick = (gt % 2 == 0) && ext_rise[gt / 2];
        default:   src_tick = 1'b0;
      endcase
    end
    assign tick[gt] = s.tc[gt].run && src_tick;
    assign ovf[gt]  = tick[gt] && (s.tv[gt] == {TW{1'b1}});

    AST_RELOAD: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      ovf[gt] && !wr_now |=> s.tv[gt] == $past(s.tr[gt]))
      else $error("timer did not reload on overflow");
    AST_PRESC: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      tick[gt] && s.tc[gt].src == SRC_PRESC |->
        ((s.presc + PRESC_W'(1)) & presc_mask(s.tc[gt].isel)) == '0)
      else $error("prescaled tick off its division boundary");
  end

  // ************************************************************
  // Channel events
  // ************************************************************
  for (genvar gc = 0; gc < NCH; gc++) begin : g_ch
    localparam int UB = (gc / NUNIT_CH) * 2;
    ccu_mode_e  md;
    logic [1:0] tsel;

    assign md            = s.cfg[gc].mode;
    assign tsel          = 2'(UB) + {1'b0, s.cfg[gc].tsel};
    assign cur_t[gc]     = s.tv[tsel];
    assign ovf_ch[gc]    = ovf[tsel];
    // Edge detection on the owned pin
    assign cap_ev[gc]    = ((md == CAP_RISE || md == CAP_BOTH) && CC_IN[gc] && !s.pin_q[gc])
                        || ((md == CAP_FALL || md == CAP_BOTH) && !CC_IN[gc] && s.pin_q[gc]);
    // Match is judged the cycle after the timer moved
    assign match_ev[gc]  = (md inside {CMP0, CMP1, CMP2, CMP3, CMP_DBL})
                        && s.upd[tsel] && (s.tv[tsel] == s.ccv[gc]);
    assign once[gc]      = (md == CMP2) || (md == CMP3);
    assign hit[gc]       = cap_ev[gc] || (match_ev[gc] && !(once[gc] && s.done[gc]));

    if ((gc % NUNIT_CH) < NHALF) begin : g_lo
      // Low channel owns the pin of a double-register pair
      // Partner toggles only when both halves of the pair are in double mode
      assign ptog[gc] = match_ev[gc + NHALF] && (s.cfg[gc + NHALF].mode == CMP_DBL)
                     && (md == CMP_DBL);
      assign tog[gc]  = (match_ev[gc] && (md == CMP1 || md == CMP_DBL)) ^ ptog[gc];
      assign drv[gc]  = md inside {CMP1, CMP3, CMP_DBL};
    end else begin : g_hi
      assign ptog[gc] = 1'b0;
      assign tog[gc]  = match_ev[gc] && (md == CMP1);
      assign drv[gc]  = md inside {CMP1, CMP3};
    end

    // Pin drive, masked on capture-only channels
    assign CC_OE[gc]  = drv[gc] && !NO_OUT_MASK[gc];
    assign CC_OUT[gc] = s.pout[gc] && !NO_OUT_MASK[gc];

    AST_CAPTURE: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      cap_ev[gc] |=> s.ccv[gc] == $past(cur_t[gc]) && s.ic[gc].request_flag)
      else $error("capture did not latch timer and flag");
    AST_IRQ: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      hit[gc] && s.ic[gc].source_enable && !wr_now |=> IRQ_REQ[gc])
      else $error("enabled event did not raise request");
    AST_TOGGLE: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      match_ev[gc] && md == CMP1 && !ptog[gc] |=> s.pout[gc] != $past(s.pout[gc]))
      else $error("mode 1 match did not toggle pin");
    AST_MODE3: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      ovf_ch[gc] && md == CMP3 && !hit[gc] && !wr_now |=> !s.pout[gc])
      else $error("mode 3 pin not cleared on overflow");
    AST_CMP0: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      match_ev[gc] && md == CMP0 |=> s.ic[gc].request_flag)
      else $error("mode 0 match did not set flag");
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_s       = s;
    next_s.presc = s.presc + PRESC_W'(1);
    next_s.upd   = tick;
    next_s.pin_q = CC_IN;
    next_s.ext_q = EXT_CNT;
    // Timer step: count or reload
    for (int t = 0; t < NTMR; t++) begin
      if (tick[t]) begin
        next_s.tv[t] = ovf[t] ? s.tr[t] : s.tv[t] + TW'(1);
      end
    end
    // Address phase capture and read wait state
    next_s.rdw = 1'b0;
    if (HREADY) begin
      next_s.dph  = accept;
      next_s.dwr  = accept && HWRITE && (HSIZE == HSIZE_WORD);
      next_s.rdw  = accept && !HWRITE;
      next_s.dadr = HADDR;
    end
    // Read data, taken after any earlier write has landed
    if (s.rdw) begin
      unique case (dec(s.dadr))
        K_CCV:   next_s.rdata = 32'(s.ccv[ci]);
        K_CFG:   next_s.rdata = 32'(s.cfg[ci]);
        K_IC:    next_s.rdata = 32'(s.ic[ci]);
        K_TV:    next_s.rdata = 32'(s.tv[ti]);
        K_TR:    next_s.rdata = 32'(s.tr[ti]);
        K_TC:    next_s.rdata = 32'(s.tc[ti]);
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    // Register write in the data phase
    if (wr_now) begin
      unique case (dec(s.dadr))
        K_CCV:   next_s.ccv[ci] = HWDATA[TW-1:0];
        K_CFG:   next_s.cfg[ci] = ccu_chcfg_s'(HWDATA[$bits(ccu_chcfg_s)-1:0]);
        K_IC:    next_s.ic[ci]  = ccu_ic_s'(HWDATA[7:0]);
        K_TV:    next_s.tv[ti]  = HWDATA[TW-1:0];
        K_TR:    next_s.tr[ti]  = HWDATA[TW-1:0];
        K_TC:    next_s.tc[ti]  = ccu_tctl_s'(HWDATA[$bits(ccu_tctl_s)-1:0]);
        default: next_s.dwr     = s.dwr;
      endcase
    end
    // Channel actions; hardware set wins over a software clear
    for (int c = 0; c < NCH; c++) begin
      if (cap_ev[c]) begin
        next_s.ccv[c] = cur_t[c];
      end
      if (ovf_ch[c]) begin
        next_s.done[c] = 1'b0;
        if (s.cfg[c].mode == CMP3) begin
          next_s.pout[c] = 1'b0;
        end
      end
      if (hit[c]) begin
        next_s.ic[c].request_flag = 1'b1;
        if (once[c]) begin
          next_s.done[c] = 1'b1;
        end
        if (s.cfg[c].mode == CMP3) begin
          next_s.pout[c] = 1'b1;
        end
      end
      if (tog[c]) begin
        next_s.pout[c] = !s.pout[c];
      end
    end
  end

  // State register
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      s <= ST_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign HREADYOUT = !s.rdw;
  assign HRDATA    = s.rdata;
  assign HRESP     = 1'b0;
  // Levels and groups go out to the interrupt arbiter
  assign SRC_CTRL  = s.ic;

  // Request gated by its enable
  for (genvar gq = 0; gq < NCH; gq++) begin : g_irq
    assign IRQ_REQ[gq] = s.ic[gq].request_flag && s.ic[gq].source_enable;
  end

  // ************************************************************
  // Global checks
  // ************************************************************
  AST_UPPER_ZERO: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s.dph && !s.dwr && !s.rdw && dec(s.dadr) == K_IC |-> HRDATA[31:8] == 24'h0)
    else $error("interrupt control upper byte not zero");

  AST_NO_OUT: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (CC_OE & NO_OUT_MASK) == '0 && (CC_OUT & NO_OUT_MASK) == '0)
    else $error("capture-only channel drives its pin");

  AST_LOCKSTEP: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s.tc[0] == s.tc[2] && s.tc[0].src == SRC_EXT && s.tv[0] == s.tv[2]
      && s.tr[0] == s.tr[2] && EXT_CNT[0] == EXT_CNT[1] && s.ext_q[0] == s.ext_q[1]
      && !wr_now |=> s.tv[0] == s.tv[2])
    else $error("first timers lost lockstep");

endmodule

// *** dual_capture_compare_array_tb.sv ***
// Self-checking bench for the dual capture/compare array
module dual_capture_compare_array_tb
  import ccu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Signals
  // ************************************************************
  logic              clk_sys = 1'b0;
  logic              arst_n  = 1'b0;
  logic              hsel    = 1'b0;
  logic              hwrite  = 1'b0;
  logic [1:0]        htrans  = 2'h0;
  logic [2:0]        hsize   = 3'h2;
  logic [31:0]       haddr   = 32'h0;
  logic [31:0]       hwdata  = 32'h0;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              hresp;
  logic [NCH-1:0]    cc_in;
  logic [NCH-1:0]    cc_out;
  logic [NCH-1:0]    cc_oe;
  logic [NCH-1:0]    irq_req;
  logic [1:0]        ext_cnt;
  logic              gpt_ovf;
  ccu_ic_s [NCH-1:0] src_ctrl;
  int                num_errors = 0;
  int                checked    = 0;
  int                c;
  int                chs[5] = '{3, 4, 5, 6, 14};
  logic [3:0]        mds[5] = '{4'h7, 4'h6, 4'h4, 4'h8, 4'h8};
  logic [31:0]       seed = 32'h4CB885D0;
  logic [31:0]       v;
  logic [31:0]       d;

  ccu_top #(.UNITS(2)) u_dut (
    .CLK_SYS(clk_sys), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp), .CC_IN(cc_in),
    .CC_OUT(cc_out), .CC_OE(cc_oe), .EXT_CNT(ext_cnt), .GPT_OVF(gpt_ovf),
    .IRQ_REQ(irq_req), .SRC_CTRL(src_ctrl)
  );

  ccu_pin_model u_pins (
    .cc_out(cc_out), .cc_oe(cc_oe), .clk(clk_sys), .cc_in(cc_in), .ext_cnt(ext_cnt),
    .gpt_ovf(gpt_ovf)
  );

  // Free-running system clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic logic [31:0] ad(input logic [31:0] base, input int i);
    return base + 32'(4 * i);
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One single AHB-Lite transfer, waiting on ready at each phase
  task automatic bus(input logic wrt, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wrt;
    haddr  <= a;
    hsize  <= HSIZE_WORD;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd);
  endtask

  task automatic rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, v, exp);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #500000;
    num_errors++;
    results();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    // Reset state and an unmapped place
    for (int i = 0; i < NCH; i++) rdc("ic reset", ad(IC_BASE, i), 32'(IC_RESET));
    chk("irq reset", irq_req, 32'h0);
    chk("okay resp", 32'(hresp), 32'h0);
    wr(32'h0000_0200, 32'hFFFF_FFFF);
    rdc("unmapped", 32'h0000_0200, 32'h0);
    // Random control words, upper bytes dropped
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      c = int'(seed[4:0]);
      seed = xs(seed);
      d = (i == 0) ? 32'hFFFF_FFFF : seed;
      wr(ad(IC_BASE, c), d);
      rdc("ic word", ad(IC_BASE, c), {24'h0, d[7:0]});
      chk("group level", 32'(src_ctrl[c].group_level), 32'(d[1:0]));
      chk("priority level", 32'(src_ctrl[c].priority_level), 32'(d[5:2]));
      chk("irq gate", 32'(irq_req[c]), 32'(d[7] & d[6]));
    end
    // Capture on a second-unit channel with timer b, all edge modes
    wr(ad(IC_BASE, 16), 32'h40);
    for (int m = 1; m <= 3; m++) begin
      seed = xs(seed);
      wr(ad(CCV_BASE, 16), 32'h0);
      wr(ad(TV_BASE, 3), {16'h0, seed[15:0]});
      wr(ad(CFG_BASE, 16), 32'h10 | 32'(m));
      u_pins.set_pin(16, 1'b1);
      repeat (3) @(posedge clk_sys);
      rdc("capture rise", ad(CCV_BASE, 16), (m == 2) ? 32'h0 : {16'h0, seed[15:0]});
      wr(ad(TV_BASE, 3), {16'h0, seed[31:16]});
      u_pins.set_pin(16, 1'b0);
      repeat (3) @(posedge clk_sys);
      d = (m == 1) ? {16'h0, seed[15:0]} : {16'h0, seed[31:16]};
      rdc("capture fall", ad(CCV_BASE, 16), d);
    end
    rdc("capture flag", ad(IC_BASE, 16), 32'hC0);
    chk("capture irq", 32'(irq_req[16]), 32'h1);
    // Toggle mode on the prescaled timer, capture-only outputs stay off
    wr(ad(TV_BASE, 0), 32'h0);
    wr(ad(CCV_BASE, 1), 32'h5);
    wr(ad(CFG_BASE, 1), 32'(CMP1));
    wr(ad(CFG_BASE, 24), 32'(CMP1));
    wr(ad(TC_BASE, 0), 32'h20);
    repeat (70) @(posedge clk_sys);
    chk("toggle pin", 32'(cc_out[1]), 32'h1);
    chk("pin enable", 32'(cc_oe[1]), 32'h1);
    chk("capture only", 32'(cc_oe[27:24]), 32'h0);
    wr(ad(TC_BASE, 0), 32'h0);
    // Compare modes on timer b clocked by general timer overflow
    wr(ad(TC_BASE, 1), 32'h28);
    wr(ad(TR_BASE, 1), 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(ad(CCV_BASE, chs[i]), (i == 4) ? 32'hFFFE : 32'hFFFF);
      wr(ad(CFG_BASE, chs[i]), {27'h0, 1'b1, mds[i]});
      wr(ad(IC_BASE, chs[i]), 32'h0);
    end
    wr(ad(TV_BASE, 1), 32'hFFFD);
    u_pins.gpt_pulse();
    chk("double set", 32'(cc_out[6]), 32'h1);
    chk("mode3 early", 32'(cc_out[3]), 32'h0);
    u_pins.gpt_pulse();
    chk("double clear", 32'(cc_out[6]), 32'h0);
    chk("mode3 set", 32'(cc_out[3]), 32'h1);
    rdc("mode2 flag", ad(IC_BASE, 4), 32'h80);
    rdc("mode0 flag", ad(IC_BASE, 5), 32'h80);
    u_pins.gpt_pulse();
    chk("mode3 ovf", 32'(cc_out[3]), 32'h0);
    wr(ad(TC_BASE, 1), 32'h0);
    rdc("reload zero", ad(TV_BASE, 1), 32'h0);
    // External counting in lockstep on both first timers
    wr(ad(TV_BASE, 0), 32'h0);
    wr(ad(TV_BASE, 2), 32'h0);
    wr(ad(TC_BASE, 0), 32'h30);
    wr(ad(TC_BASE, 2), 32'h30);
    u_pins.ext_pulses(2'h3, 7);
    repeat (4) @(posedge clk_sys);
    wr(ad(TC_BASE, 0), 32'h0);
    wr(ad(TC_BASE, 2), 32'h0);
    rdc("ext count", ad(TV_BASE, 0), 32'h7);
    rdc("ext lockstep", ad(TV_BASE, 2), 32'h7);
    // Prescaler codes give divide by eight, doubling
    for (int k = 0; k < 3; k++) begin
      wr(ad(TV_BASE, 1), 32'h0);
      wr(ad(TC_BASE, 1), 32'h20 | 32'(k));
      repeat (20 << (k + 3)) @(posedge clk_sys);
      wr(ad(TC_BASE, 1), 32'h0);
      bus(1'b0, ad(TV_BASE, 1), 32'h0);
      chk("prescale", 32'(v >= 32'd19 && v <= 32'd22), 32'h1);
    end
    results();
  end
endmodule
